// ==== hdl/edmwh_ctrl.sv ====
// Purpose: wait state insertion, bus hold grant and X/Y access checking
//          for external data memory cycles.
// Assumes: ref_clk is the processor clock; wait and hold request pins are asynchronous.
// Notes:   one access request outstanding at a time.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
module edmwh_ctrl
  import edmwh_pkg::*;
#(
  parameter bit SIX_BANK = 1'b1
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // register port
  input  wire edmwh_pkg::edmwh_regbus_t regBus,
  output logic [15:0]                 regRdData,
  // core access side
  input  wire edmwh_pkg::edmwh_req_t  req,
  output edmwh_pkg::edmwh_result_t    result,
  output logic                        busy,
  // external pins
  input  wire logic                   wait_n,
  input  wire logic                   hold_request_n,
  output logic                        bus_strobe_n,
  output logic                        hold_grant_n
);

  import edmwh_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_HOLD
  } edmwh_fsm_t;

  typedef struct packed {
    edmwh_fsm_t                fsm;
    logic [15:0]               waitCfg;
    logic [WAIT_CNT_W-1:0]     waitCnt;
    logic                      burst;
    logic                      pendValid;
    edmwh_req_t                pendReq;
    logic                      curBurst;
    logic [15:0]               rdData;
    edmwh_result_t             result;
    logic                      strobeN;
    logic                      grantN;
    logic                      busy;
  } edmwh_state_t;

  edmwh_state_t state_q;
  edmwh_state_t state_d;

  logic waitSync;
  logic holdReqSync;

  // pin synchronisers; adds two cycles of latency to both pins
  edmwh_sync #(
    .W       (2),
    .RST_VAL (1'b1)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn ({wait_n, hold_request_n}),
    .syncOut ({waitSync, holdReqSync})
  );

  // field code to wait cycle count
  function automatic logic [WAIT_CNT_W-1:0] codeToWaits(
    input logic [1:0] code
  );
    logic [WAIT_CNT_W-1:0] w;
    w = WAITS_CODE0;
    unique case (code)
      2'h0: w = WAITS_CODE0;
      2'h1: w = WAITS_CODE1;
      2'h2: w = WAITS_CODE2;
      2'h3: w = WAITS_CODE3;
    endcase
    return w;
  endfunction

  // programmed waits for one X or Y address
  function automatic logic [WAIT_CNT_W-1:0] bankWaits(
    input logic [15:0] cfg,
    input logic        isY,
    input logic [15:0] addr
  );
    logic [1:0] bank;
    int         lsb;
    bank = addr[BANK_MSB:BANK_LSB];
    // two-bank parts have one field per space
    if (!SIX_BANK) begin
      bank = TWO_BANK_SEL;
    end
    lsb = FIELD_W * int'(bank);
    if (isY) begin
      lsb = lsb + FIELD_Y_BASE;
    end
    return codeToWaits(cfg[lsb +: FIELD_W]);
  endfunction

  // may the two sides run in parallel
  function automatic logic pairAllowed(
    input edmwh_region_t xr,
    input edmwh_region_t yr
  );
    logic ok;
    ok = 1'b1;
    if (xr == REGION_INT_RAM || yr == REGION_INT_RAM) begin
      ok = 1'b1;
    end else if (xr == REGION_PERIPH && yr == REGION_PERIPH) begin
      ok = 1'b0;
    end else if (xr == REGION_PERIPH || yr == REGION_PERIPH) begin
      ok = 1'b1;
    end else begin
      // what is left is ROM or external on both sides
      ok = 1'b0;
    end
    return ok;
  endfunction

  // writable bits of the configuration register
  function automatic logic [15:0] cfgMask();
    return SIX_BANK ? MASK_SIX_BANK : MASK_TWO_BANK;
  endfunction

  edmwh_req_t  startReq;
  logic        startNow;
  logic        xExt;
  logic        yExt;
  logic [15:0] cfgNow;

  always_comb begin
    // a pending request goes first; a fresh one otherwise
    startNow = state_q.pendValid || req.start;
    startReq = state_q.pendValid ? state_q.pendReq : req;
    xExt     = startReq.xRegion == REGION_EXT;
    yExt     = startReq.yRegion == REGION_EXT;
  end

  always_comb begin
    state_d = state_q;
    cfgNow  = state_q.waitCfg;

    state_d.result  = '0;
    state_d.rdData  = '0;

    // register writes; reserved bits never store, so they read as zero
    if (regBus.wr && regBus.addr == OFF_WAIT_CFG) begin
      state_d.waitCfg = regBus.wrData & cfgMask();
      // the very next access already sees the new setting
      cfgNow          = state_d.waitCfg;
    end

    // register reads, answered in the following cycle
    if (regBus.rd) begin
      unique case (regBus.addr)
        OFF_WAIT_CFG: state_d.rdData = state_q.waitCfg;
        OFF_STATUS: begin
          state_d.rdData[STAT_GRANT]   = ~state_q.grantN;
          state_d.rdData[STAT_BUSY]    = state_q.busy;
          state_d.rdData[STAT_BURST]   = state_q.burst;
          state_d.rdData[STAT_WAITPIN] = ~waitSync;
          state_d.rdData[STAT_HOLDREQ] = ~holdReqSync;
          state_d.rdData[STAT_PEND]    = state_q.pendValid;
        end
        default: state_d.rdData = '0;
      endcase
    end

    unique case (state_q.fsm)
      ST_IDLE: begin
        if (startNow) begin
          state_d.pendValid = 1'b0;
          if (!pairAllowed(startReq.xRegion, startReq.yRegion)) begin
            // refused pairs run no bus cycle at all
            state_d.result.refused = 1'b1;
            state_d.strobeN        = 1'b1;
            state_d.burst          = 1'b0;
          end else if (xExt || yExt) begin
            // programmed waits of the addressed bank, pin not consulted
            state_d.waitCnt  = xExt
                             ? bankWaits(cfgNow, 1'b0, startReq.xAddr)
                             : bankWaits(cfgNow, 1'b1, startReq.yAddr);
            state_d.curBurst = startReq.burst;
            state_d.strobeN  = 1'b0;
            state_d.burst    = 1'b1;
            state_d.fsm      = ST_ACCESS;
          end else begin
            // internal only: one cycle, no external bus use
            state_d.result.done = 1'b1;
            state_d.strobeN     = 1'b1;
            state_d.burst       = 1'b0;
          end
        end else if (state_q.burst) begin
          // back-to-back run still open: bus kept, no grant yet
          state_d.strobeN = 1'b0;
        end else if (!holdReqSync) begin
          // hold request from the outside master
          state_d.grantN  = 1'b0;
          state_d.strobeN = 1'b1;
          state_d.fsm     = ST_HOLD;
        end
      end

      ST_ACCESS: begin
        if (req.start && !state_q.pendValid) begin
          state_d.pendValid = 1'b1;
          state_d.pendReq   = req;
        end
        if (state_q.waitCnt != '0) begin
          state_d.waitCnt = state_q.waitCnt - WAIT_CNT_W'(1);
        end else if (!waitSync) begin
          // final cycle sampled low: one more wait cycle
          state_d.waitCnt = '0;
        end else begin
          state_d.result.done = 1'b1;
          state_d.burst       = state_q.curBurst;
          // strobe stays low across a back-to-back run
          state_d.strobeN     = ~state_q.curBurst;
          state_d.fsm         = ST_IDLE;
        end
      end

      ST_HOLD: begin
        // accesses raised now wait for the bus to come back
        if (req.start && !state_q.pendValid) begin
          state_d.pendValid = 1'b1;
          state_d.pendReq   = req;
        end
        if (holdReqSync) begin
          // release seen: grant high first, own access next cycle
          state_d.grantN = 1'b1;
          state_d.fsm    = ST_IDLE;
        end else begin
          state_d.grantN = 1'b0;
        end
      end

      default: begin
        state_d.fsm     = ST_IDLE;
        state_d.grantN  = 1'b1;
        state_d.strobeN = 1'b1;
      end
    endcase

    // an open back-to-back run still owns the bus, so it counts as busy
    state_d.busy = (state_d.fsm != ST_IDLE) || state_d.pendValid
                || state_d.burst;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q           <= '0;
      state_q.fsm       <= ST_IDLE;
      state_q.waitCfg   <= WAIT_CFG_RST & (SIX_BANK ? MASK_SIX_BANK
                                                    : MASK_TWO_BANK);
      state_q.strobeN   <= 1'b1;
      state_q.grantN    <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // every output straight from the state register
  assign regRdData    = state_q.rdData;
  assign result       = state_q.result;
  assign busy         = state_q.busy;
  assign bus_strobe_n = state_q.strobeN;
  assign hold_grant_n = state_q.grantN;

endmodule

// ==== hdl/edmwh_pkg.sv ====
// Purpose: shared constants and types for the external data memory
//          wait and bus hold controller.
// Assumes: 16-bit register port, 16-bit data addresses.
// Notes:   field layout is shared by the six-bank and two-bank variants.
package edmwh_pkg;

  // register port
  localparam int          EDMWH_ADDR_W  = 4;
  localparam int          EDMWH_DATA_W  = 16;
  localparam logic [3:0]  OFF_WAIT_CFG  = 4'h0;
  localparam logic [3:0]  OFF_STATUS    = 4'h1;

  // data_wait_config reset value and writable bits per variant
  localparam logic [15:0] WAIT_CFG_RST  = 16'hffff;
  localparam logic [15:0] MASK_SIX_BANK = 16'hfcfc;
  localparam logic [15:0] MASK_TWO_BANK = 16'hc0c0;

  // field positions: bank b of X at 2*b, bank b of Y at Y_BASE + 2*b
  localparam int          FIELD_W       = 2;
  localparam int          FIELD_Y_BASE  = 8;
  localparam logic [1:0]  TWO_BANK_SEL  = 2'h3;

  // bank number comes from the top address bits
  localparam int          BANK_MSB      = 15;
  localparam int          BANK_LSB      = 14;

  // wait cycles per field code
  localparam int          WAIT_CNT_W    = 3;
  localparam logic [2:0]  WAITS_CODE0   = 3'h0;
  localparam logic [2:0]  WAITS_CODE1   = 3'h1;
  localparam logic [2:0]  WAITS_CODE2   = 3'h3;
  localparam logic [2:0]  WAITS_CODE3   = 3'h7;

  // status register bit positions
  localparam int          STAT_GRANT    = 0;
  localparam int          STAT_BUSY     = 1;
  localparam int          STAT_BURST    = 2;
  localparam int          STAT_WAITPIN  = 3;
  localparam int          STAT_HOLDREQ  = 4;
  localparam int          STAT_PEND     = 5;

  typedef enum logic [1:0] {
    REGION_INT_ROM,
    REGION_INT_RAM,
    REGION_EXT,
    REGION_PERIPH
  } edmwh_region_t;

  // one access request of an instruction, X and Y side together
  typedef struct packed {
    logic          start;
    logic          burst;
    edmwh_region_t xRegion;
    edmwh_region_t yRegion;
    logic [15:0]   xAddr;
    logic [15:0]   yAddr;
  } edmwh_req_t;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wrData;
  } edmwh_regbus_t;

  // per-access outcome
  typedef struct packed {
    logic done;
    logic refused;
  } edmwh_result_t;

endpackage

// ==== hdl/edmwh_sync.sv ====
// Purpose: two-flop synchroniser for the asynchronous input pins.
// Assumes: single destination clock.
// Notes:   first stage feeds only the second stage.
`timescale 1ns/100ps
module edmwh_sync #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } edmwh_sync_state_t;

  edmwh_sync_state_t state_q;
  edmwh_sync_state_t state_d;

  always_comb begin
    state_d        = state_q;
    state_d.stage1 = asyncIn;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= {(2 * W){RST_VAL}};
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;

endmodule

// ==== test/edmwh_bus_partner.sv ====
// Purpose: slow memory and second bus master on the pins.
// Assumes: controls change just after a clock edge.
// Notes:   asks for the bus once per raise of holdWant.
`timescale 1ns/100ps
module edmwh_bus_partner (
  // clock
  input wire logic ref_clk,
  // scenario controls
  input wire logic stretch,
  input wire logic holdWant,
  // pins
  input wire logic hold_grant_n,
  output logic     wait_n,
  output logic     hold_request_n
);
  logic [3:0] useCnt;
  initial begin
    wait_n = 1'b1;
    hold_request_n = 1'b1;
    useCnt = 4'h0;
  end
  always @(posedge ref_clk) begin
    wait_n <= !stretch;
    if (!holdWant) begin
      hold_request_n <= 1'b1;
      useCnt <= 4'h0;
    end else if (!hold_grant_n) begin
      // bus in use for eight cycles, then handed back
      useCnt <= useCnt + 4'h1;
      if (useCnt == 4'h7) hold_request_n <= 1'b1;
    end else if (useCnt == 4'h0) begin
      hold_request_n <= 1'b0;
    end
  end
endmodule

// ==== test/edmwh_ctrl_monitor.sv ====
// Purpose: port checker for the wait and hold controller.
// Assumes: pins pass a two-flop synchroniser before use.
// Notes:   bound to every instance, both variants.
`timescale 1ns/100ps
module edmwh_ctrl_monitor #(
  parameter bit SIX_BANK = 1'b1
) (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  // register port
  input wire edmwh_pkg::edmwh_regbus_t regBus,
  input wire logic [15:0]              regRdData,
  // core side
  input wire edmwh_pkg::edmwh_req_t    req,
  input wire edmwh_pkg::edmwh_result_t result,
  input wire logic                     busy,
  // pins
  input wire logic                     wait_n,
  input wire logic                     hold_request_n,
  input wire logic                     bus_strobe_n,
  input wire logic                     hold_grant_n
);
  import edmwh_pkg::*;
  logic [15:0] cfgMask;
  logic        badPair;
  logic        extSide;
  assign cfgMask = SIX_BANK ? MASK_SIX_BANK : MASK_TWO_BANK;
  assign badPair = req.xRegion != REGION_INT_RAM
                && req.yRegion != REGION_INT_RAM
                && (req.xRegion == REGION_PERIPH)
                == (req.yRegion == REGION_PERIPH);
  assign extSide = req.xRegion == REGION_EXT || req.yRegion == REGION_EXT;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence cfgWrite;
    regBus.wr && regBus.addr == OFF_WAIT_CFG;
  endsequence
  sequence cfgRead;
    regBus.rd && regBus.addr == OFF_WAIT_CFG;
  endsequence
  sequence accStart;
    req.start && !busy;
  endsequence
  AST_CFG_MASK: assert property (cfgWrite ##1 cfgRead |=>
    regRdData == ($past(regBus.wrData, 2) & cfgMask))
    else $error("config readback not masked");
  AST_STROBE_OWN: assert property (!bus_strobe_n |-> busy && hold_grant_n)
    else $error("strobe low outside own access");
  AST_GRANT_NO_OWN: assert property (!hold_grant_n |-> bus_strobe_n)
    else $error("own access during grant");
  AST_GRANT_CAUSE: assert property ($fell(hold_grant_n) |->
    !$past(hold_request_n, 2) && $past(bus_strobe_n))
    else $error("grant without request or mid cycle");
  AST_GRANT_HOLD: assert property (!hold_grant_n && !hold_request_n
    |=> !hold_grant_n) else $error("grant dropped early");
  AST_GRANT_END: assert property ($rose(hold_grant_n)
    |-> $past(hold_request_n, 2)) else $error("grant ended early");
  AST_PAIR_REFUSE: assert property (accStart ##0 badPair
    |=> result.refused && bus_strobe_n) else $error("pair not refused");
  AST_PAIR_INT: assert property (accStart ##0 !badPair && !extSide
    |=> result.done && !result.refused) else $error("internal pair lost");
  AST_PAIR_EXT: assert property (accStart ##0 !badPair && extSide
    |=> !bus_strobe_n && !result.refused) else $error("ext pair lost");
  AST_WAIT_PIN: assert property ((!wait_n && !bus_strobe_n) [*5]
    |-> !result.done) else $error("done while wait pin low");
endmodule
bind edmwh_ctrl edmwh_ctrl_monitor #(.SIX_BANK(SIX_BANK)) u_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .regBus(regBus),
  .regRdData(regRdData), .req(req), .result(result), .busy(busy),
  .wait_n(wait_n), .hold_request_n(hold_request_n),
  .bus_strobe_n(bus_strobe_n), .hold_grant_n(hold_grant_n)
);

// ==== test/edmwh_ctrl_tb_top.sv ====
// Purpose: directed test of wait insertion, pairing and bus hold.
// Assumes: six-bank instance checked, two-bank one for register masks.
// Notes:   partner drives both instances' pins.
`timescale 1ns/100ps
module edmwh_ctrl_tb_top;
  import edmwh_pkg::*;
  logic ref_clk, rst_n, busy, stretch, holdWant;
  logic wait_n, hold_request_n, bus_strobe_n, hold_grant_n;
  logic [15:0] regRdData, rdData2;
  edmwh_regbus_t regBus;
  edmwh_req_t    req;
  edmwh_result_t result;
  int badCount, testsRun, cnt;
  logic rf;
  logic [2:0] waitTab [4];
  edmwh_ctrl #(.SIX_BANK(1'b1)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .regBus(regBus), .regRdData(regRdData), .req(req), .result(result),
    .busy(busy), .wait_n(wait_n), .hold_request_n(hold_request_n),
    .bus_strobe_n(bus_strobe_n), .hold_grant_n(hold_grant_n));
  edmwh_ctrl #(.SIX_BANK(1'b0)) u_dut2 (.ref_clk(ref_clk), .rst_n(rst_n),
    .regBus(regBus), .regRdData(rdData2), .req(req), .result(),
    .busy(), .wait_n(wait_n), .hold_request_n(hold_request_n),
    .bus_strobe_n(), .hold_grant_n());
  edmwh_bus_partner u_partner (.ref_clk(ref_clk), .stretch(stretch),
    .holdWant(holdWant), .hold_grant_n(hold_grant_n), .wait_n(wait_n),
    .hold_request_n(hold_request_n));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("tests %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    testsRun++;
    if (g !== e) begin
      badCount++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic regWr(input logic [3:0] a, input logic [15:0] d);
    regBus.wr <= 1'b1;
    regBus.addr <= a;
    regBus.wrData <= d;
    @(posedge ref_clk);
    regBus.wr <= 1'b0;
  endtask
  task automatic regRd(input logic [3:0] a, input logic [15:0] e6,
                       input logic [15:0] e2);
    regBus.rd <= 1'b1;
    regBus.addr <= a;
    @(posedge ref_clk);
    regBus.rd <= 1'b0;
    #1;
    chk("rdData", e6, regRdData);
    chk("rdData2", e2, rdData2);
  endtask
  // counts strobe-low cycles until done or refused
  task automatic acc(input int x, input int y, input logic [15:0] xa,
                     input logic [15:0] ya, input logic bst);
    int i;
    req <= '{1'b1, bst, edmwh_region_t'(x), edmwh_region_t'(y), xa, ya};
    @(posedge ref_clk);
    req.start <= 1'b0;
    cnt = 0;
    for (i = 0; i < 60; i++) begin
      #1;
      if (result.done === 1'b1 || result.refused === 1'b1) break;
      cnt += int'(bus_strobe_n === 1'b0);
      @(posedge ref_clk);
    end
    rf = result.refused;
    if (i == 60) begin
      badCount++;
      conclude();
    end
  endtask
  initial begin
    regBus = '0;
    req = '0;
    {stretch, holdWant, badCount, testsRun} = '0;
    waitTab = '{WAITS_CODE0, WAITS_CODE1, WAITS_CODE2, WAITS_CODE3};
    rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("pins", 16'h6, {bus_strobe_n, hold_grant_n, busy});
    regRd(OFF_WAIT_CFG, MASK_SIX_BANK, MASK_TWO_BANK);
    regRd(OFF_STATUS, 16'h0000, 16'h0000);
    regWr(OFF_WAIT_CFG, 16'h0000);
    regRd(OFF_WAIT_CFG, 16'h0000, 16'h0000);
    regWr(OFF_WAIT_CFG, 16'hffff);
    regRd(OFF_WAIT_CFG, 16'hfcfc, 16'hc0c0);
    regWr(4'h9, 16'hffff);
    regRd(4'h9, 16'h0000, 16'h0000);
    $display("test registers end");
    for (int c = 0; c < 4; c++) begin
      // write and access back to back: new setting must already apply
      regWr(OFF_WAIT_CFG, 16'(c << 2) | 16'((3 - c) << 12));
      acc(2, 1, 16'h4000, 16'h0, 1'b0);
      chk("xBank1", 16'(1 + waitTab[c]), 16'(cnt));
      acc(1, 2, 16'h0, 16'h8000, 1'b0);
      chk("yBank2", 16'(1 + waitTab[3 - c]), 16'(cnt));
    end
    $display("test waits end");
    regWr(OFF_WAIT_CFG, 16'h0004);
    stretch <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fork
      acc(2, 1, 16'h4000, 16'h0, 1'b0);
      begin
        repeat (12) @(posedge ref_clk);
        stretch <= 1'b0;
      end
    join
    chk("stretch", 16'h1, 16'(cnt >= 11 && cnt <= 18));
    $display("test wait pin end");
    for (int x = 0; x < 4; x++) begin
      for (int y = 0; y < 4; y++) begin
        acc(x, y, 16'h4000, 16'h4000, 1'b0);
        chk("refused", 16'(x != 1 && y != 1 && (x == 3) == (y == 3)),
            16'(rf));
      end
    end
    $display("test pairs end");
    regWr(OFF_WAIT_CFG, 16'h000c);
    holdWant <= 1'b1;
    acc(2, 1, 16'h4000, 16'h0, 1'b1);
    chk("grantBurst", 16'h1, 16'(hold_grant_n));
    acc(2, 1, 16'h4000, 16'h0, 1'b0);
    chk("grantLast", 16'h1, 16'(hold_grant_n));
    for (int i = 0; i < 20 && hold_grant_n !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("grant", 16'h0, 16'(hold_grant_n));
    // held start must wait for the bus to come back
    acc(2, 1, 16'h4000, 16'h0, 1'b0);
    chk("heldCnt", 16'h8, 16'(cnt));
    chk("grantOff", 16'h1, 16'(hold_grant_n));
    holdWant <= 1'b0;
    $display("test hold end");
    conclude();
  end
endmodule
